/* File: inc/acr_pkg.sv */
// Summary of operation
// - one write updates every field of a register
// - address 00h bit 1 resets all, self-clears
// - 00h bit 0: pin shows overrange or readback
// - 01h bits 7-2 hold the swing code
// - swing code applies only when override enabled
// - 03h bits 1-0: only 11 selects best tuning
// - tuning settable only through serial writes
// - 25h bits 7-4 gain, 0101 is 0 dB
// - defaults: 25h=50h, 42h=08h, others 00h
// - 25h bits 2-0 select the test pattern
// - 14-bit custom pattern from 3Fh and 40h
// - 3Dh bits 7-6 select output format
`default_nettype none
package acr_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int ACR_NUM_REGS = 15;
	localparam int ACR_IDX_SOFT = 0;
	localparam int ACR_IDX_SWING = 1;
	localparam int ACR_IDX_PERF_A = 2;
	localparam int ACR_IDX_GAIN_TEST = 3;
	localparam int ACR_IDX_DRIVE = 4;
	localparam int ACR_IDX_FORMAT = 5;
	localparam int ACR_IDX_PAT_HI = 6;
	localparam int ACR_IDX_PAT_LO = 7;
	localparam int ACR_IDX_IFACE_CLK = 8;
	localparam int ACR_IDX_FALL_STBY = 9;
	localparam int ACR_IDX_POWER = 10;
	localparam int ACR_IDX_PERF_B = 11;
	localparam int ACR_IDX_PEDESTAL = 12;
	localparam int ACR_IDX_LOOP = 13;
	localparam int ACR_IDX_LOW_RATE = 14;

	localparam logic [7:0] ACR_REG_ADDR [ACR_NUM_REGS] = '{
		8'h00, 8'h01, 8'h03, 8'h25, 8'h26, 8'h3D, 8'h3F, 8'h40,
		8'h41, 8'h42, 8'h43, 8'h4A, 8'hBF, 8'hCF, 8'hDF};
	localparam logic [7:0] ACR_REG_RESET [ACR_NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// bits software may change; all others stay at their reset value
	localparam logic [7:0] ACR_REG_WMASK [ACR_NUM_REGS] = '{
		8'h01, 8'hFC, 8'h03, 8'hF7, 8'h03, 8'hE0, 8'h3F, 8'hFF,
		8'hFF, 8'hC4, 8'h53, 8'h01, 8'hFC, 8'hBC, 8'h30};

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ACR_SOFT_RESET_BIT = 1;
	localparam int ACR_READOUT_BIT = 0;
	localparam logic [1:0] ACR_PERF_A_BEST = 2'h3;
	localparam logic [1:0] ACR_SWING_EN_ON = 2'h3;
	localparam logic [5:0] ACR_SWING_DEFAULT = 6'h00;
	localparam logic [3:0] ACR_GAIN_ZERO_DB = 4'h5;
	localparam logic [3:0] ACR_GAIN_MAX = 4'hC;
	localparam logic [1:0] ACR_FMT_TWOS = 2'h2;
	localparam logic [1:0] ACR_FMT_OFFSET = 2'h3;
	localparam logic [1:0] ACR_IF_LVDS = 2'h1;
	localparam logic [1:0] ACR_IF_CMOS = 2'h3;

	// ----------------------------------------
	// serial framing
	// ----------------------------------------
	localparam int ACR_BYTE_BITS = 8;
	localparam logic [2:0] ACR_LAST_BIT = 3'h7;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ACR_PAT_NORMAL = 3'b000,
		ACR_PAT_ZEROS = 3'b001,
		ACR_PAT_ONES = 3'b010,
		ACR_PAT_TOGGLE = 3'b011,
		ACR_PAT_RAMP = 3'b100,
		ACR_PAT_CUSTOM = 3'b101
	} acr_pattern_t;

	typedef enum logic [0:0] {
		ACR_RX_ADDR = 1'b0,
		ACR_RX_DATA = 1'b1
	} acr_rx_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} acr_wr_t;

	typedef struct packed {
		logic [7:0] val;
	} acr_cell_t;

	typedef struct packed {
		acr_rx_state_t state;
		logic sclk_prev;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] addr;
		logic load_pending;
		logic [7:0] sdout;
		acr_wr_t wr;
	} acr_rx_t;

	typedef struct packed {
		logic readout_en;
		logic swing_override;
		logic [5:0] swing_code;
		logic perf_a_best;
		logic perf_b;
		logic [2:0] gain_steps;
		logic gain_reserved;
		acr_pattern_t pattern_sel;
		logic [13:0] custom_pattern;
		logic clkout_2x;
		logic data_2x;
		logic offset_binary;
		logic offset_corr_en;
		logic use_cmos;
		logic [1:0] cmos_clk_strength;
		logic clk_rise_en;
		logic [1:0] clk_rise_posn;
		logic clk_fall_en;
		logic [1:0] clk_fall_posn;
		logic standby;
		logic pdn_global;
		logic pdn_obuf;
		logic [5:0] pedestal;
		logic freeze_corr;
		logic [3:0] corr_time_const;
		logic [1:0] low_speed;
	} acr_cfg_t;

endpackage
`default_nettype wire

/* File: logic/acr_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// serial configuration pins
	input wire logic serial_reset_in,
	input wire logic sclk_in,
	input wire logic sen_b_in,
	input wire logic sdata_in,
	// straps and datapath status
	input wire logic format_strap_offset_in,
	input wire logic format_strap_cmos_in,
	input wire logic overrange_in,
	// shared output pin
	output logic overrange_readback_pin_out,
	// decoded configuration
	output acr_pkg::acr_cfg_t cfg_out
);

	// ----------------------------------------
	// serial front end
	// ----------------------------------------
	acr_pkg::acr_wr_t wr;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic sdout;

	acr_serial_rx u_rx (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.sclk_in(sclk_in),
		.sen_b_in(sen_b_in),
		.sdata_in(sdata_in),
		.rd_data_in(rd_data),
		.rd_addr_out(rd_addr),
		.wr_out(wr),
		.sdout_out(sdout)
	);

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] q [acr_pkg::ACR_NUM_REGS];
	logic soft_reset;
	logic clear_all;
	logic readout;

	assign readout = q[acr_pkg::ACR_IDX_SOFT][acr_pkg::ACR_READOUT_BIT];
	// the reset bit is never stored, so it reads back as zero
	assign soft_reset = wr.valid && (wr.addr == acr_pkg::ACR_REG_ADDR[acr_pkg::ACR_IDX_SOFT])
		&& wr.data[acr_pkg::ACR_SOFT_RESET_BIT];
	// a held reset pin also freezes every setting at default
	assign clear_all = soft_reset || serial_reset_in;

	genvar gi;
	generate
		for (gi = 0; gi < acr_pkg::ACR_NUM_REGS; gi++) begin : g_reg
			logic wr_hit;
			// readback mode locks everything but the control register
			assign wr_hit = wr.valid && (wr.addr == acr_pkg::ACR_REG_ADDR[gi])
				&& (!readout || (gi == acr_pkg::ACR_IDX_SOFT));
			acr_reg_cell #(
				.RESET_VAL(acr_pkg::ACR_REG_RESET[gi]),
				.WMASK(acr_pkg::ACR_REG_WMASK[gi])
			) u_cell (
				.clock_in(clock_in),
				.rst_b_in(rst_b_in),
				.clear_in(clear_all),
				.wr_en_in(wr_hit),
				.wr_data_in(wr.data),
				.q_out(q[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// readback mux
	// ----------------------------------------
	always_comb begin
		rd_data = 8'h00;
		// control register is not readable; unmapped addresses give zero
		for (int i = 1; i < acr_pkg::ACR_NUM_REGS; i++) begin
			if (rd_addr == acr_pkg::ACR_REG_ADDR[i]) begin
				rd_data = q[i];
			end
		end
	end

	// ----------------------------------------
	// decoded outputs
	// ----------------------------------------
	typedef struct packed {
		logic pin;
		acr_pkg::acr_cfg_t cfg;
	} acr_top_t;

	acr_top_t s_ff;
	acr_top_t nxt_s;

	logic [7:0] r_swing;
	logic [7:0] r_gain;
	logic [7:0] r_fmt;
	logic [7:0] r_ifc;
	logic [7:0] r_fall;
	logic [7:0] r_pwr;
	logic [7:0] r_loop;

	assign r_swing = q[acr_pkg::ACR_IDX_SWING];
	assign r_gain = q[acr_pkg::ACR_IDX_GAIN_TEST];
	assign r_fmt = q[acr_pkg::ACR_IDX_FORMAT];
	assign r_ifc = q[acr_pkg::ACR_IDX_IFACE_CLK];
	assign r_fall = q[acr_pkg::ACR_IDX_FALL_STBY];
	assign r_pwr = q[acr_pkg::ACR_IDX_POWER];
	assign r_loop = q[acr_pkg::ACR_IDX_LOOP];

	always_comb begin
		nxt_s = s_ff;
		nxt_s.pin = readout ? sdout : overrange_in;
		nxt_s.cfg.readout_en = readout;

		nxt_s.cfg.swing_override = (r_pwr[1:0] == acr_pkg::ACR_SWING_EN_ON);
		nxt_s.cfg.swing_code = nxt_s.cfg.swing_override ? r_swing[7:2]
			: acr_pkg::ACR_SWING_DEFAULT;

		// the two reserved codes behave as default tuning
		nxt_s.cfg.perf_a_best = (q[acr_pkg::ACR_IDX_PERF_A][1:0] == acr_pkg::ACR_PERF_A_BEST);
		nxt_s.cfg.perf_b = q[acr_pkg::ACR_IDX_PERF_B][0];

		// reserved gain codes fall back to 0 dB rather than an odd gain
		if ((r_gain[7:4] >= acr_pkg::ACR_GAIN_ZERO_DB) && (r_gain[7:4] <= acr_pkg::ACR_GAIN_MAX)) begin
			nxt_s.cfg.gain_steps = 3'(r_gain[7:4] - acr_pkg::ACR_GAIN_ZERO_DB);
			nxt_s.cfg.gain_reserved = 1'b0;
		end else begin
			nxt_s.cfg.gain_steps = 3'h0;
			nxt_s.cfg.gain_reserved = 1'b1;
		end

		case (r_gain[2:0])
			3'h0: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_NORMAL;
			3'h1: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_ZEROS;
			3'h2: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_ONES;
			3'h3: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_TOGGLE;
			3'h4: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_RAMP;
			3'h5: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_CUSTOM;
			default: nxt_s.cfg.pattern_sel = acr_pkg::ACR_PAT_NORMAL;
		endcase
		nxt_s.cfg.custom_pattern = {q[acr_pkg::ACR_IDX_PAT_HI][5:0], q[acr_pkg::ACR_IDX_PAT_LO]};

		nxt_s.cfg.clkout_2x = q[acr_pkg::ACR_IDX_DRIVE][1];
		nxt_s.cfg.data_2x = q[acr_pkg::ACR_IDX_DRIVE][0];

		case (r_fmt[7:6])
			acr_pkg::ACR_FMT_TWOS: nxt_s.cfg.offset_binary = 1'b0;
			acr_pkg::ACR_FMT_OFFSET: nxt_s.cfg.offset_binary = 1'b1;
			default: nxt_s.cfg.offset_binary = format_strap_offset_in;
		endcase
		nxt_s.cfg.offset_corr_en = r_fmt[5];

		case (r_ifc[7:6])
			acr_pkg::ACR_IF_LVDS: nxt_s.cfg.use_cmos = 1'b0;
			acr_pkg::ACR_IF_CMOS: nxt_s.cfg.use_cmos = 1'b1;
			default: nxt_s.cfg.use_cmos = format_strap_cmos_in;
		endcase
		nxt_s.cfg.cmos_clk_strength = r_ifc[5:4];
		nxt_s.cfg.clk_rise_en = r_ifc[3];
		nxt_s.cfg.clk_rise_posn = r_ifc[2:1];
		nxt_s.cfg.clk_fall_en = r_ifc[0];
		nxt_s.cfg.clk_fall_posn = r_fall[7:6];

		// with the reset pin tied high the data pin doubles as standby
		nxt_s.cfg.standby = r_fall[2] || (serial_reset_in && sdata_in);
		nxt_s.cfg.pdn_global = r_pwr[6];
		nxt_s.cfg.pdn_obuf = r_pwr[4];

		nxt_s.cfg.pedestal = q[acr_pkg::ACR_IDX_PEDESTAL][7:2];
		nxt_s.cfg.freeze_corr = r_loop[7];
		nxt_s.cfg.corr_time_const = r_loop[5:2];
		nxt_s.cfg.low_speed = q[acr_pkg::ACR_IDX_LOW_RATE][5:4];
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign overrange_readback_pin_out = s_ff.pin;
	assign cfg_out = s_ff.cfg;

endmodule
`default_nettype wire

/* File: logic/acr_reg_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_reg_cell #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// control
	input wire logic clear_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	// value
	output logic [7:0] q_out
);

	acr_pkg::acr_cell_t s_ff;
	acr_pkg::acr_cell_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (clear_in) begin
			nxt_s.val = RESET_VAL;
		end else if (wr_en_in) begin
			// whole byte lands at once; fixed bits keep their value
			nxt_s.val = (wr_data_in & WMASK) | (RESET_VAL & ~WMASK);
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_ff <= '{val: RESET_VAL};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q_out = s_ff.val;

endmodule
`default_nettype wire

/* File: logic/acr_serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_serial_rx (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// serial pins
	input wire logic sclk_in,
	input wire logic sen_b_in,
	input wire logic sdata_in,
	// register side
	input wire logic [7:0] rd_data_in,
	output logic [7:0] rd_addr_out,
	output acr_pkg::acr_wr_t wr_out,
	output logic sdout_out
);

	acr_pkg::acr_rx_t s_ff;
	acr_pkg::acr_rx_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.wr.valid = 1'b0;
		nxt_s.sclk_prev = sclk_in;
		if (s_ff.load_pending) begin
			// read data follows the address by one cycle
			nxt_s.sdout = rd_data_in;
			nxt_s.load_pending = 1'b0;
		end
		if (sen_b_in) begin
			// partial words are dropped when the frame ends
			nxt_s.state = acr_pkg::ACR_RX_ADDR;
			nxt_s.bit_cnt = '0;
		end else if (s_ff.sclk_prev && !sclk_in) begin
			nxt_s.shift = {s_ff.shift[6:0], sdata_in};
			nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
			nxt_s.sdout = {s_ff.sdout[6:0], 1'b0};
			if (s_ff.bit_cnt == acr_pkg::ACR_LAST_BIT) begin
				case (s_ff.state)
					acr_pkg::ACR_RX_ADDR: begin
						nxt_s.addr = {s_ff.shift[6:0], sdata_in};
						nxt_s.load_pending = 1'b1;
						nxt_s.state = acr_pkg::ACR_RX_DATA;
					end
					acr_pkg::ACR_RX_DATA: begin
						nxt_s.wr.valid = 1'b1;
						nxt_s.wr.addr = s_ff.addr;
						nxt_s.wr.data = {s_ff.shift[6:0], sdata_in};
						nxt_s.state = acr_pkg::ACR_RX_ADDR;
					end
					default: begin
						nxt_s.state = acr_pkg::ACR_RX_ADDR;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rd_addr_out = s_ff.addr;
	assign wr_out = s_ff.wr;
	assign sdout_out = s_ff.sdout[7];

endmodule
`default_nettype wire

/* File: verif/acr_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_asserts (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// pins
	input wire logic serial_reset_in,
	input wire logic sclk_in,
	input wire logic sen_b_in,
	input wire logic sdata_in,
	input wire logic format_strap_offset_in,
	input wire logic format_strap_cmos_in,
	input wire logic overrange_in,
	input wire logic overrange_readback_pin_out,
	input wire acr_pkg::acr_cfg_t cfg_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// -------------------------
	// sequences
	// -------------------------
	sequence s_idle4;
		(sen_b_in && !serial_reset_in)[*4];
	endsequence
	// five quiet samples cover the three-edge load-to-pin delay
	sequence s_rd_quiet;
		(cfg_out.readout_en && $stable(sclk_in))[*5];
	endsequence
	// -------------------------
	// checks
	// -------------------------
	a_pin_overrange: assert property (
		$past(rst_b_in) && !cfg_out.readout_en |-> overrange_readback_pin_out == $past(overrange_in))
		else $error("pin does not follow overrange");
	a_readback_hold: assert property (s_rd_quiet |-> $stable(overrange_readback_pin_out))
		else $error("readback pin moved without a clock fall");
	a_swing_gated: assert property (!cfg_out.swing_override |-> cfg_out.swing_code == 6'h00)
		else $error("swing code active without override");
	a_gain_reserved: assert property (cfg_out.gain_reserved |-> cfg_out.gain_steps == 3'h0)
		else $error("reserved gain code applied a gain");
	a_pattern_legal: assert property (cfg_out.pattern_sel <= acr_pkg::ACR_PAT_CUSTOM)
		else $error("unused pattern code passed through");
	a_hwreset_tune: assert property (
		serial_reset_in[*3] |-> !cfg_out.perf_a_best && cfg_out.custom_pattern == 14'h0000)
		else $error("settings not held at default under reset pin");
	a_standby_pin: assert property (serial_reset_in && sdata_in |=> cfg_out.standby)
		else $error("standby from data pin missing");
	a_idle_hold: assert property (
		s_idle4 |-> $stable(cfg_out.custom_pattern) && $stable(cfg_out.perf_a_best))
		else $error("setting changed without a serial word");
endmodule
`default_nettype wire

/* File: verif/acr_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs_tb_top;
	logic clock_in;
	logic rst_b_in;
	logic serial_reset_in;
	logic sclk_in;
	logic sen_b_in;
	logic m_sdata;
	logic sr_sdata;
	logic strap_ob;
	logic ovr;
	logic pin;
	acr_pkg::acr_cfg_t cfg;
	logic [7:0] rd;
	logic [7:0] a;
	int n_mismatch;
	int compares;
	int cyc;
	acr_config_regs acr_config_regs_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.serial_reset_in(serial_reset_in), .sclk_in(sclk_in), .sen_b_in(sen_b_in),
		.sdata_in(m_sdata | sr_sdata), .format_strap_offset_in(strap_ob), .format_strap_cmos_in(1'b0),
		.overrange_in(ovr), .overrange_readback_pin_out(pin), .cfg_out(cfg));
	acr_ctrl_model acr_ctrl_model_inst (.clock_in(clock_in), .sclk_out(sclk_in), .sen_b_out(sen_b_in),
		.sdata_out(m_sdata), .sdout_in(pin));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		acr_ctrl_model_inst.xfer(ad, d, rd);
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
		acr_ctrl_model_inst.xfer(ad, 8'h00, rd);
		chk("readback", {8'h00, rd}, {8'h00, e});
	endtask
	function automatic logic [7:0] dflt(input logic [7:0] ad);
		return (ad == 8'h25) ? 8'h50 : (ad == 8'h42) ? 8'h08 : 8'h00;
	endfunction
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// a full run needs about 9300 cycles
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		rst_b_in = 1'b0;
		serial_reset_in = 1'b0;
		sr_sdata = 1'b0;
		strap_ob = 1'b1;
		ovr = 1'b0;
		n_mismatch = 0;
		compares = 0;
		cyc = 0;
		repeat (5) @(negedge clock_in);
		rst_b_in = 1'b1;
		ovr = 1'b1;
		repeat (2) @(negedge clock_in);
		chk("ovr pin", pin, 1'b1);
		ovr = 1'b0;
		chk("strap format", cfg.offset_binary, 1'b1);
		wr(8'h00, 8'h01);
		for (int i = 1; i < 15; i++) begin
			rdchk(acr_pkg::ACR_REG_ADDR[i], dflt(acr_pkg::ACR_REG_ADDR[i]));
		end
		wr(8'h01, 8'h6C);
		rdchk(8'h01, 8'h00);
		wr(8'h00, 8'h00);
		chk("readout off", cfg.readout_en, 1'b0);
		$display("test defaults done");
		wr(8'h01, 8'h6C);
		chk("swing gated", cfg.swing_code, 6'h00);
		wr(8'h43, 8'h03);
		chk("swing code", cfg.swing_code, 6'h1B);
		wr(8'h03, 8'h01);
		chk("tune a reserved", cfg.perf_a_best, 1'b0);
		wr(8'h03, 8'h03);
		chk("tune a", cfg.perf_a_best, 1'b1);
		wr(8'h4A, 8'h01);
		chk("tune b", cfg.perf_b, 1'b1);
		wr(8'h25, 8'hC5);
		chk("gain and pattern", {cfg.gain_steps, cfg.pattern_sel}, {3'h7, 3'h5});
		wr(8'h25, 8'h30);
		chk("gain reserved", {cfg.gain_reserved, cfg.gain_steps}, {1'b1, 3'h0});
		wr(8'h3F, 8'h3F);
		wr(8'h40, 8'hA5);
		chk("custom pattern", cfg.custom_pattern, 14'h3FA5);
		wr(8'h3D, 8'h80);
		chk("twos format", cfg.offset_binary, 1'b0);
		wr(8'h3D, 8'hC0);
		chk("offset format", cfg.offset_binary, 1'b1);
		for (int p = 0; p < 8; p++) begin
			wr(8'h25, {5'h0A, p[2:0]});
			chk("pattern", cfg.pattern_sel, (p > 5) ? 3'h0 : p[2:0]);
		end
		chk("gain zero", cfg.gain_steps, 3'h0);
		$display("test fields done");
		for (int i = 1; i < 15; i++) begin
			wr(acr_pkg::ACR_REG_ADDR[i], 8'hFF);
		end
		chk("wide fields", {cfg.pedestal, cfg.corr_time_const, cfg.low_speed, cfg.pdn_global, cfg.pdn_obuf},
			{6'h3F, 4'hF, 2'h3, 1'b1, 1'b1});
		chk("swing full", {cfg.swing_override, cfg.swing_code}, {1'b1, 6'h3F});
		wr(8'h00, 8'h01);
		for (int i = 1; i < 15; i++) begin
			a = acr_pkg::ACR_REG_ADDR[i];
			rdchk(a, acr_pkg::ACR_REG_WMASK[i] | (dflt(a) & ~acr_pkg::ACR_REG_WMASK[i]));
		end
		$display("test fixed bits done");
		wr(8'h00, 8'h02);
		chk("soft reset readout", cfg.readout_en, 1'b0);
		wr(8'h00, 8'h01);
		rdchk(8'h25, 8'h50);
		rdchk(8'h01, 8'h00);
		wr(8'h00, 8'h00);
		$display("test soft reset done");
		serial_reset_in = 1'b1;
		wr(8'h03, 8'h03);
		chk("tune blocked", cfg.perf_a_best, 1'b0);
		sr_sdata = 1'b1;
		repeat (2) @(negedge clock_in);
		chk("standby pin", cfg.standby, 1'b1);
		sr_sdata = 1'b0;
		serial_reset_in = 1'b0;
		$display("test reset pin done");
		test_done();
	end
endmodule
bind acr_config_regs acr_asserts acr_asserts_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
	.serial_reset_in(serial_reset_in), .sclk_in(sclk_in), .sen_b_in(sen_b_in), .sdata_in(sdata_in),
	.format_strap_offset_in(format_strap_offset_in), .format_strap_cmos_in(format_strap_cmos_in),
	.overrange_in(overrange_in), .overrange_readback_pin_out(overrange_readback_pin_out), .cfg_out(cfg_out));
`default_nettype wire

/* File: verif/acr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_model (
	// clock
	input wire logic clock_in,
	// serial pins
	output logic sclk_out,
	output logic sen_b_out,
	output logic sdata_out,
	input wire logic sdout_in
);
	initial begin
		sclk_out = 1'b0;
		sen_b_out = 1'b1;
		sdata_out = 1'b0;
	end
	// one word, msb first; the data byte is read back from the pin before each fall
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
		logic [15:0] w;
		w = {a, d};
		@(negedge clock_in);
		sen_b_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sclk_out = 1'b1;
			sdata_out = w[i];
			repeat (4) @(negedge clock_in);
			if (i < 8) rd[i] = sdout_in;
			sclk_out = 1'b0;
			repeat (4) @(negedge clock_in);
		end
		sen_b_out = 1'b1;
		// released line: never leave the last bit standing
		sdata_out = ~sdata_out;
	endtask
endmodule
`default_nettype wire
